/* waveform_output_shaper_defines.svh */
// Purpose: offsets, field positions, reset values and mode codes of the waveform shaper
// Assumes: 32-bit Avalon-MM data path with byte addresses
// Notes: the types that go with these constants live in shaper_pkg
//
// Summary of operation
// - a 3-bit mode field selects one of seven output behaviours
// - pass-through mode holds the start gate low
// - compare-gated mode: gate select picks low, compare 0, compare 1 or their OR
// - timer-gated mode: gate select picks low, active flag 0, flag 1 or their OR
// - both compare dead-time modes force the start gate low
// - both pulse dead-time modes build the gate as compare-gated mode does
// - pass-through: each output carries its compare input or the pulse input
// - compare-gated: outputs carry compare inputs, ANDed with pulse where applied
// - timer-gated: outputs carry active flags, ANDed with pulse where applied
// - compare dead-time: compare 1 edges start the timer, outputs non-overlapping pair
// - filtered compare dead-time: short compare 1 pulses removed before dead-time logic
// - filtered pulse dead-time: pulse input width-filtered before dead-time logic
// - pulse dead-time: pulse input edges start the timer directly
// - polarity 00 keeps both outputs normal, 01 inverts both
// - polarity 10 inverts output 0 only, 11 inverts output 1 only
// - dead-time and filter values may be rewritten at any time
// - writing the mode sets initial output and gate levels at once
// - pulse source select picks the pulse generator channel used as pulse input
// - clock divide select sets the tick rate of timer and pulse counter
// - timer-gated: compare rising edge sets its flag, count end clears both flags
// - dead-time: rising source drops output 1 now, output 0 rises after count
`ifndef WAVEFORM_OUTPUT_SHAPER_DEFINES_SVH
`define WAVEFORM_OUTPUT_SHAPER_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SHAPER_CONTROL 5'h00
`define OFS_DEAD_TIME_FIRST 5'h04
`define OFS_DEAD_TIME_SECOND 5'h08
`define OFS_FILTER_WIDTH 5'h0c
`define OFS_SHAPER_STATUS 5'h10

// ----------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------
`define RST_SHAPER_CONTROL 16'h0000
`define RST_TIME_VALUE 16'h0000
`define MODE_THROUGH 3'h0
`define MODE_CMP_GATED 3'h1
`define MODE_TMR_GATED 3'h2
`define MODE_CMP_DEAD 3'h4
`define MODE_CMP_DEAD_FILT 3'h5
`define MODE_PLS_DEAD_FILT 3'h6
`define MODE_PLS_DEAD 3'h7

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define STAT_FLAG0_BIT 0
`define STAT_FLAG1_BIT 1
`define STAT_TIMER_BUSY_BIT 2
`define STAT_FILTER_BUSY_BIT 3
`define STAT_DEAD_LEVEL0_BIT 4
`define STAT_DEAD_LEVEL1_BIT 5

`endif

/* shaper_pkg.sv */
// Purpose: types shared by the waveform shaper
// Assumes: field layout of the control word as listed in the struct below
// Notes: the struct is 16 bits, low bit first from the bottom of the list
package shaper_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spare_hi;
    logic [2:0] clock_divide_select;
    logic [1:0] pulse_source_select;
    logic [1:0] output_polarity_select;
    logic [1:0] pulse_apply_select;
    logic [1:0] gate_output_select;
    logic spare_lo;
    logic [2:0] operating_mode_select;
  } shaper_ctrl_t;

  // registered result bundle: gate plus both shaped outputs
  typedef struct packed {
    logic gate;
    logic [1:0] shaped;
  } shaper_out_t;

endpackage

/* waveform_output_shaper.sv */
// Purpose: one waveform shaper channel pair with an Avalon-MM register slave
// Assumes: compare and pulse inputs come from logic on CLK_SYS
// Notes: timers and filters advance on the divided tick only
`timescale 1ns/1ns
`include "waveform_output_shaper_defines.svh"

module waveform_output_shaper (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // register bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // inputs from the compare unit and the pulse generator
  input wire logic [1:0] COMPARE_IN,
  input wire logic [3:0] PULSE_CH_IN,
  // shaped outputs
  output logic [1:0] SHAPED_OUT,
  output logic PULSE_START_GATE
);
  import shaper_pkg::*;

  shaper_ctrl_t ctrl_reg;
  logic [15:0] dt_first_reg;
  logic [15:0] dt_second_reg;
  logic [15:0] filt_width_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic bus_req;
  logic bus_commit;
  logic [15:0] wdata_lo;
  logic mode_wr;
  logic [2:0] mode_next;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_mask;
  logic tick;
  logic pulse_in;
  logic pulse_new;
  logic [1:0] cmp_prev_reg;
  logic [1:0] cmp_rise;
  logic flag0_reg;
  logic flag1_reg;
  logic [15:0] tmr_cnt_reg;
  logic tmr_busy_reg;
  logic tmr_done;
  logic filt_raw;
  logic filt_level_reg;
  logic filt_busy_reg;
  logic [15:0] filt_cnt_reg;
  logic dt_src;
  logic dt_prev_reg;
  logic [1:0] dead_reg;
  shaper_out_t sel;
  shaper_out_t out_reg;
  logic [2:0] mode;

  assign mode = ctrl_reg.operating_mode_select;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  // one wait cycle: the access completes at the edge where waitrequest is seen low
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_commit = AVS_WRITE & ~wait_reg;
  assign wdata_lo = AVS_WRITEDATA[15:0];
  assign mode_wr = bus_commit && (AVS_ADDRESS == `OFS_SHAPER_CONTROL) && AVS_BYTEENABLE[0];
  assign mode_next = AVS_WRITEDATA[2:0];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      wait_reg <= 1'b1;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // read data is captured when the wait cycle ends; unmapped words read zero
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ && wait_reg) begin
      case (AVS_ADDRESS)
        `OFS_SHAPER_CONTROL: rdata_reg <= {16'h0000, ctrl_reg};
        `OFS_DEAD_TIME_FIRST: rdata_reg <= {16'h0000, dt_first_reg};
        `OFS_DEAD_TIME_SECOND: rdata_reg <= {16'h0000, dt_second_reg};
        `OFS_FILTER_WIDTH: rdata_reg <= {16'h0000, filt_width_reg};
        `OFS_SHAPER_STATUS: begin
          rdata_reg <= 32'h0000_0000;
          rdata_reg[`STAT_FLAG0_BIT] <= flag0_reg;
          rdata_reg[`STAT_FLAG1_BIT] <= flag1_reg;
          rdata_reg[`STAT_TIMER_BUSY_BIT] <= tmr_busy_reg;
          rdata_reg[`STAT_FILTER_BUSY_BIT] <= filt_busy_reg;
          rdata_reg[`STAT_DEAD_LEVEL0_BIT] <= dead_reg[0];
          rdata_reg[`STAT_DEAD_LEVEL1_BIT] <= dead_reg[1];
        end
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA = rdata_reg;

  // control word; fields are meant to stay put once neighbours run
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_reg <= `RST_SHAPER_CONTROL;
    end else if (bus_commit && AVS_ADDRESS == `OFS_SHAPER_CONTROL) begin
      if (AVS_BYTEENABLE[0]) begin
        ctrl_reg[7:0] <= {wdata_lo[7:4], 1'b0, wdata_lo[2:0]};
      end
      if (AVS_BYTEENABLE[1]) begin
        ctrl_reg[15:8] <= {1'b0, wdata_lo[14:8]};
      end
    end
  end

  // time values take effect at the next load, so rewrites are safe any time
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      dt_first_reg <= `RST_TIME_VALUE;
      dt_second_reg <= `RST_TIME_VALUE;
      filt_width_reg <= `RST_TIME_VALUE;
    end else if (bus_commit) begin
      for (int b = 0; b < 2; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          case (AVS_ADDRESS)
            `OFS_DEAD_TIME_FIRST: dt_first_reg[b*8 +: 8] <= wdata_lo[b*8 +: 8];
            `OFS_DEAD_TIME_SECOND: dt_second_reg[b*8 +: 8] <= wdata_lo[b*8 +: 8];
            `OFS_FILTER_WIDTH: filt_width_reg[b*8 +: 8] <= wdata_lo[b*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // clock divider and input selection
  // ----------------------------------------------------------------
  // tick every 2^n cycles, n from the divide field
  assign div_mask = 8'(({1'b0, 8'h01} << ctrl_reg.clock_divide_select) - 9'h001);
  assign tick = ((div_cnt_reg & div_mask) == div_mask);

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // pulse channel chosen by the source field
  assign pulse_in = PULSE_CH_IN[ctrl_reg.pulse_source_select];

  // a mode write presets from the channel that the same write selects
  assign pulse_new = PULSE_CH_IN[AVS_BYTEENABLE[1] ? wdata_lo[11:10] :
                                 ctrl_reg.pulse_source_select];

  // compare edges are judged between ticks so short glitches between ticks are ignored
  assign cmp_rise = COMPARE_IN & ~cmp_prev_reg;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      cmp_prev_reg <= 2'h0;
    end else if (mode_wr || tick) begin
      cmp_prev_reg <= COMPARE_IN;
    end
  end

  // ----------------------------------------------------------------
  // shared timer and active flags
  // ----------------------------------------------------------------
  assign tmr_done = tick && tmr_busy_reg && (tmr_cnt_reg == 16'h0000);

  // timer-gated flags: set by compare rises, cleared together at count end
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || mode_wr) begin
      flag0_reg <= 1'b0;
      flag1_reg <= 1'b0;
    end else if (mode == `MODE_TMR_GATED && tick) begin
      if (|cmp_rise) begin
        flag0_reg <= flag0_reg | cmp_rise[0];
        flag1_reg <= flag1_reg | cmp_rise[1];
      end else if (tmr_done) begin
        flag0_reg <= 1'b0;
        flag1_reg <= 1'b0;
      end
    end
  end

  // one down-counter serves the timer-gated and the dead-time modes
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || mode_wr) begin
      tmr_cnt_reg <= 16'h0000;
      tmr_busy_reg <= 1'b0;
    end else if (tick) begin
      if (mode == `MODE_TMR_GATED && |cmp_rise) begin
        tmr_busy_reg <= 1'b1;
        // a simultaneous rise of both loads the first value
        tmr_cnt_reg <= cmp_rise[0] ? dt_first_reg : dt_second_reg;
      end else if (mode[2] && dt_src != dt_prev_reg) begin
        tmr_busy_reg <= 1'b1;
        tmr_cnt_reg <= dt_src ? dt_second_reg : dt_first_reg;
      end else if (tmr_done) begin
        tmr_busy_reg <= 1'b0;
      end else if (tmr_busy_reg) begin
        tmr_cnt_reg <= tmr_cnt_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pulse width filter
  // ----------------------------------------------------------------
  // compare 1 or pulse input is the filtered source
  assign filt_raw = (mode == `MODE_CMP_DEAD_FILT) ? COMPARE_IN[1] : pulse_in;

  // the level moves only after the raw input held the new value for the width
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      filt_level_reg <= 1'b0;
      filt_busy_reg <= 1'b0;
      filt_cnt_reg <= 16'h0000;
    end else if (mode_wr) begin
      filt_level_reg <= (mode_next == `MODE_CMP_DEAD_FILT) ? COMPARE_IN[1] : pulse_new;
      filt_busy_reg <= 1'b0;
    end else if (tick) begin
      if (filt_raw == filt_level_reg) begin
        filt_busy_reg <= 1'b0; // pulse shorter than the width: dropped
      end else if (!filt_busy_reg) begin
        filt_busy_reg <= 1'b1;
        filt_cnt_reg <= filt_width_reg;
      end else if (filt_cnt_reg == 16'h0000) begin
        filt_busy_reg <= 1'b0;
        filt_level_reg <= filt_raw;
      end else begin
        filt_cnt_reg <= filt_cnt_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // dead-time pair
  // ----------------------------------------------------------------
  // source per dead-time mode
  always_comb begin
    case (mode)
      `MODE_CMP_DEAD: dt_src = COMPARE_IN[1];
      `MODE_CMP_DEAD_FILT: dt_src = filt_level_reg;
      `MODE_PLS_DEAD_FILT: dt_src = filt_level_reg;
      `MODE_PLS_DEAD: dt_src = pulse_in;
      default: dt_src = 1'b0;
    endcase
  end

  // on a mode write the pair starts as source and its complement
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      dt_prev_reg <= 1'b0;
      dead_reg <= 2'h2;
    end else if (mode_wr) begin
      if (mode_next == `MODE_CMP_DEAD || mode_next == `MODE_CMP_DEAD_FILT) begin
        dt_prev_reg <= COMPARE_IN[1];
        dead_reg <= {~COMPARE_IN[1], COMPARE_IN[1]};
      end else begin
        dt_prev_reg <= pulse_new;
        dead_reg <= {~pulse_new, pulse_new};
      end
    end else if (tick && mode[2]) begin
      dt_prev_reg <= dt_src;
      if (dt_src && !dt_prev_reg) begin
        dead_reg[1] <= 1'b0; // rising source drops output 1 at once
      end else if (!dt_src && dt_prev_reg) begin
        dead_reg[0] <= 1'b0; // falling source drops output 0 at once
      end else if (tmr_done) begin
        // count end raises the side the source now favours
        if (dt_src) begin
          dead_reg[0] <= 1'b1;
        end else begin
          dead_reg[1] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // gate and output selection
  // ----------------------------------------------------------------
  // gate and shaped outputs per mode, polarity applied last
  always_comb begin
    sel = '0;
    case (mode)
      `MODE_THROUGH: begin
        sel.gate = 1'b0;
        for (int i = 0; i < 2; i++) begin
          sel.shaped[i] = ctrl_reg.pulse_apply_select[i] ? pulse_in : COMPARE_IN[i];
        end
      end
      `MODE_CMP_GATED, `MODE_PLS_DEAD_FILT, `MODE_PLS_DEAD: begin
        sel.gate = |(ctrl_reg.gate_output_select & COMPARE_IN);
        if (mode == `MODE_CMP_GATED) begin
          for (int i = 0; i < 2; i++) begin
            sel.shaped[i] = COMPARE_IN[i] &
              (pulse_in | ~ctrl_reg.pulse_apply_select[i]);
          end
        end else begin
          sel.shaped = dead_reg;
        end
      end
      `MODE_TMR_GATED: begin
        sel.gate = |(ctrl_reg.gate_output_select & {flag1_reg, flag0_reg});
        for (int i = 0; i < 2; i++) begin
          sel.shaped[i] = (i == 0 ? flag0_reg : flag1_reg) &
            (pulse_in | ~ctrl_reg.pulse_apply_select[i]);
        end
      end
      `MODE_CMP_DEAD, `MODE_CMP_DEAD_FILT: begin
        sel.gate = 1'b0;
        sel.shaped = dead_reg;
      end
      default: sel = '0;
    endcase
    case (ctrl_reg.output_polarity_select)
      2'h0: sel.shaped = sel.shaped;
      2'h1: sel.shaped = ~sel.shaped;
      2'h2: sel.shaped = sel.shaped ^ 2'h1;
      default: sel.shaped = sel.shaped ^ 2'h2;
    endcase
  end

  // registered every cycle, not just on ticks, so outputs track inputs closely
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      out_reg <= '0;
    end else begin
      out_reg <= sel;
    end
  end

  assign SHAPED_OUT = out_reg.shaped;
  assign PULSE_START_GATE = out_reg.gate;

endmodule

/* shaper_asserts.sv */
// Purpose: port-level checks of the waveform shaper
// Assumes: control is written through byte lanes 0 and 1
// Notes: control is mirrored from bus writes at the edge they complete
`timescale 1ns/1ns
`include "waveform_output_shaper_defines.svh"
module shaper_asserts (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // register bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // shaper link
  input wire logic [1:0] COMPARE_IN,
  input wire logic [3:0] PULSE_CH_IN,
  input wire logic [1:0] SHAPED_OUT,
  input wire logic PULSE_START_GATE
);
  import shaper_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  shaper_ctrl_t ctrl_reg;
  shaper_ctrl_t old_reg;
  logic live_reg;
  logic [2:0] want_reg;
  logic [2:0] want;
  logic [2:0] md;
  logic quiet;
  // mirror of control; bits 3 and 15 never stick
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_reg <= '0;
    end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_SHAPER_CONTROL) begin
      if (AVS_BYTEENABLE[0]) ctrl_reg[7:0] <= AVS_WRITEDATA[7:0] & 8'hf7;
      if (AVS_BYTEENABLE[1]) ctrl_reg[15:8] <= AVS_WRITEDATA[15:8] & 8'h7f;
    end
  end
  // outputs are registered, so compare against last cycle's selection
  always_ff @(posedge CLK_SYS) begin
    live_reg <= RSTN;
    old_reg <= ctrl_reg;
    want_reg <= want;
  end
  // selection worked out from the mirrored control
  always_comb begin
    want[2] = ctrl_reg.gate_output_select[0] & COMPARE_IN[0];
    want[2] = want[2] | (ctrl_reg.gate_output_select[1] & COMPARE_IN[1]);
    want[1:0] = COMPARE_IN & ({2{PULSE_CH_IN[ctrl_reg.pulse_source_select]}}
                | ~ctrl_reg.pulse_apply_select);
    if (ctrl_reg.operating_mode_select == `MODE_THROUGH) begin
      want[1:0] = ctrl_reg.pulse_apply_select & {2{PULSE_CH_IN[ctrl_reg.pulse_source_select]}}
                  | ~ctrl_reg.pulse_apply_select & COMPARE_IN;
    end
    want[1:0] = want[1:0] ^ {ctrl_reg.output_polarity_select[0],
                             ^ctrl_reg.output_polarity_select};
    md = old_reg.operating_mode_select;
    quiet = live_reg && old_reg == ctrl_reg && old_reg.output_polarity_select == 2'h0
            && old_reg.clock_divide_select == 3'h0;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_gate_through_low: assert property (live_reg && md == 3'h0 |-> !PULSE_START_GATE)
    else $error("start gate high in pass-through");
  a_gate_cmp_sel: assert property (live_reg && md inside {3'h1, 3'h6, 3'h7}
    |-> PULSE_START_GATE == want_reg[2]) else $error("start gate selection wrong");
  a_gate_dead_low: assert property (live_reg && md inside {3'h4, 3'h5}
    |-> !PULSE_START_GATE) else $error("start gate high in compare dead-time");
  a_out_through: assert property (live_reg && md == 3'h0
    |-> SHAPED_OUT == want_reg[1:0]) else $error("pass-through output wrong");
  a_out_cmp_gated: assert property (live_reg && md == 3'h1
    |-> SHAPED_OUT == want_reg[1:0]) else $error("compare-gated output wrong");
  a_pair_no_overlap: assert property (quiet && $past(quiet) && md[2]
    |-> SHAPED_OUT != 2'b11) else $error("dead-time pair overlaps");
  a_dead_drop_now: assert property (quiet && md == 3'h4 && $rose(COMPARE_IN[1])
    |-> ##2 SHAPED_OUT == 2'b00) else $error("output 1 not dropped on rise");
  a_flag_set_rise: assert property (quiet && md == 3'h2 && !old_reg.pulse_apply_select[0]
    && $rose(COMPARE_IN[0]) |-> ##2 SHAPED_OUT[0] [*2])
    else $error("active flag 0 not set on rise");
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus request not answered next cycle");
  a_wait_one_cycle: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  // main scenarios
  c_dead_rise: cover property (quiet && md == 3'h4 && $rose(COMPARE_IN[1]));
  c_flag_rise: cover property (quiet && md == 3'h2 && $rose(COMPARE_IN[0]));
  c_write_done: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

bind waveform_output_shaper shaper_asserts i_chk (.CLK_SYS, .RSTN, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .COMPARE_IN, .PULSE_CH_IN, .SHAPED_OUT, .PULSE_START_GATE);

/* far_side_model.sv */
// Purpose: stand-in for the compare unit and the pulse generator
// Assumes: the bench commands levels; the model launches them from flops
// Notes: levels move only on the clock, as the real units drive from registers
`timescale 1ns/1ns
module far_side_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // commands from the bench
  input wire logic [1:0] cmp_cmd,
  input wire logic [3:0] pls_cmd,
  // levels toward the shaper
  output logic [1:0] cmp_out,
  output logic [3:0] pls_out
);
  // quiet while in reset, so no edge reaches the shaper before setup
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_out <= 2'h0;
      pls_out <= 4'h0;
    end else begin
      cmp_out <= cmp_cmd;
      pls_out <= pls_cmd;
    end
  end
endmodule

/* tb.sv */
// Purpose: self-checking bench for the waveform shaper
// Assumes: one-cycle bus answer; outputs one cycle after inputs
// Notes: selection is swept over a table; timers are checked by counting cycles
`timescale 1ns/1ns
`include "waveform_output_shaper_defines.svh"
module tb;
  import shaper_pkg::*;
  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic [1:0] cmp_cmd = 2'h0;
  logic [3:0] pls_cmd = 4'h0;
  logic [31:0] rdat;
  logic waitreq;
  logic [1:0] cmp;
  logic [3:0] pls;
  logic [1:0] shaped;
  logic gate;
  int n_fail = 0;
  int cmp_count = 0;
  int c;
  shaper_ctrl_t cw;
  logic [31:0] q;
  logic [2:0] e;
  logic [3:0] pv;
  logic [2:0] mlist [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [4:0] ta [3] = '{`OFS_DEAD_TIME_FIRST, `OFS_DEAD_TIME_SECOND, `OFS_FILTER_WIDTH};
  logic [15:0] tv [3] = '{16'h0006, 16'h0004, 16'h0003};
  // free-running system clock
  always #5 clk = ~clk;
  waveform_output_shaper i_dut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(waitreq), .COMPARE_IN(cmp), .PULSE_CH_IN(pls), .SHAPED_OUT(shaped),
    .PULSE_START_GATE(gate));
  far_side_model i_far (.clk(clk), .rstn(rstn), .cmp_cmd(cmp_cmd), .pls_cmd(pls_cmd),
    .cmp_out(cmp), .pls_out(pls));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // one access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= {16'h0, d};
    be <= b;
    // no limit of its own: a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] m, input logic [5:0] k);
    cw = '0;
    cw.operating_mode_select = m;
    cw.gate_output_select = k[1:0];
    cw.pulse_apply_select = k[3:2];
    cw.output_polarity_select = k[5:4];
    cw.pulse_source_select = k[1:0] ^ k[5:4];
    bus(1'b1, `OFS_SHAPER_CONTROL, cw, 4'h3);
  endtask
  task automatic put(input logic [1:0] cv, input logic [3:0] p);
    @(posedge clk);
    cmp_cmd <= cv;
    pls_cmd <= p;
  endtask
  // counts cycles in a window where the chosen condition holds
  task automatic count(input int n, input int sel);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += sel == 0 ? shaped === 2'b00 : sel == 1 ? shaped[0] === 1'b1
           : sel == 2 ? gate === 1'b1 : shaped !== 2'b10;
    end
  endtask
  function automatic logic [2:0] model(input logic [2:0] m, input logic [5:0] k,
                                       input logic [2:0] i);
    logic [1:0] o;
    logic g;
    g = (k[1:0] == 2'h1) ? i[0] : (k[1:0] == 2'h2) ? i[1] : k[1:0] == 2'h3 && i[1:0] != 0;
    if (!(m == 3'h1 || m >= 3'h6)) g = 1'b0;
    o = m == 3'h0 ? {k[3] ? i[2] : i[1], k[2] ? i[2] : i[0]} : i[1:0] & ~(k[3:2] & ~{2{i[2]}});
    if (m == 3'h3) o = 2'b00;
    return {g, o ^ (k[5:4] == 2'h1 ? 2'b11 : k[5:4] == 2'h2 ? 2'b01 : {k[5:4] == 2'h3, 1'b0})};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // watchdog sized well beyond the roughly 13k cycles the tests take
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // reset values, reserved bits, byte lanes, unmapped place
    bus(1'b0, `OFS_SHAPER_CONTROL, 16'h0, 4'h3);
    check(q, 32'h0);
    bus(1'b1, `OFS_SHAPER_CONTROL, 16'hffff, 4'h3);
    bus(1'b1, `OFS_SHAPER_CONTROL, 16'h0, 4'h2);
    bus(1'b0, `OFS_SHAPER_CONTROL, 16'h0, 4'h3);
    check(q, 32'h00f7);
    bus(1'b0, `OFS_SHAPER_STATUS, 16'h0, 4'h3);
    check(q, 32'h20);
    bus(1'b1, 5'h14, 16'h1234, 4'h3);
    bus(1'b0, 5'h14, 16'h0, 4'h3);
    check(q, 32'h0);
    for (int j = 0; j < 3; j++) begin
      bus(1'b0, ta[j], 16'h0, 4'h3);
      check(q, 32'h0);
      bus(1'b1, ta[j], tv[j], 4'h3);
      bus(1'b0, ta[j], 16'h0, 4'h3);
      check(q, {16'h0, tv[j]});
    end
    $display("test registers done");
    // every gate select, pulse apply and polarity, per input and per mode other than timer-gated
    foreach (mlist[j]) for (int k = 0; k < 64; k++) begin
      put(2'h0, 4'h0);
      cfg(mlist[j], k[5:0]);
      for (int i = 0; i < 8; i++) begin
        pv = 4'h1 << (k[1:0] ^ k[5:4]);
        put(i[1:0], i[2] ? pv : ~pv);
        repeat (2) @(posedge clk);
        @(negedge clk);
        e = model(mlist[j], k[5:0], i[2:0]);
        check(gate, e[2]);
        if (mlist[j] < 3'h4) check(shaped, e[1:0]);
      end
    end
    $display("test selection done");
    // timer-gated: flags stand for the loaded count plus one tick
    put(2'h0, 4'h0);
    cfg(3'h2, 6'h03);
    put(2'h1, 4'h0);
    count(20, 1);
    check(c, 7);
    bus(1'b1, `OFS_DEAD_TIME_SECOND, 16'h0002, 4'h3);
    put(2'h2, 4'h0);
    count(20, 2);
    check(c, 3);
    bus(1'b1, `OFS_DEAD_TIME_SECOND, 16'h0004, 4'h3);
    // divide field 1: a tick every second cycle, so seven ticks take fourteen cycles
    put(2'h0, 4'h0);
    bus(1'b1, `OFS_SHAPER_CONTROL, 16'h1002, 4'h3);
    put(2'h1, 4'h0);
    count(40, 1);
    check(c, 14);
    $display("test timer done");
    // dead-time modes: preset pair, glitch filtering, both dead times
    for (int m = 4; m < 8; m++) begin
      put(2'h0, 4'h0);
      count(20, 0);
      cfg(m[2:0], 6'h00);
      @(negedge clk);
      count(4, 3);
      check(c, 0);
      if (m[0] ^ m[1]) begin
        put({m < 6, 1'b0}, {4{m > 5}});
        put(2'h0, 4'h0);
        count(20, 3);
        check(c, 0);
      end
      put({m < 6, 1'b0}, {4{m > 5}});
      count(30, 0);
      check(c, 5);
      put(2'h0, 4'h0);
      count(30, 0);
      check(c, 7);
    end
    $display("test dead-time done");
    complete_run;
  end
endmodule
